// file: rad_pkg.sv
package rad_pkg;
	localparam int          ADDR_W       = 6;
	localparam logic [5:0]  A_REVISION   = 6'h00;
	localparam logic [5:0]  A_SYNTH_A    = 6'h01;
	localparam logic [5:0]  A_SYNTH_N    = 6'h02;
	localparam logic [5:0]  A_CODE       = 6'h11;
	localparam logic [5:0]  A_CODE_LAST  = 6'h18;
	localparam logic [5:0]  A_CHANNEL    = 6'h21;
	localparam logic [5:0]  A_MFG        = 6'h3C;
	localparam logic [63:0] CODE_RESET   = 64'h1E8B6A3DE0E9B222;
	localparam logic [7:0]  SYNTH_A_MASK = 8'h1F;
	localparam logic [7:0]  SYNTH_N_MASK = 8'h7F;
	localparam logic [6:0]  SYNTH_N_BASE = 7'h4A;
	localparam int          CMD_DIR_BIT  = 7;
	localparam int          CMD_INC_BIT  = 6;
	localparam int          CHAN_MODE    = 7;
	// Status byte slots on the device user side
	localparam int          ST_COUNT     = 8;
	// Host controller register map
	localparam logic [7:0]  H_CTRL       = 8'h00;
	localparam logic [7:0]  H_TXDATA     = 8'h04;
	localparam logic [7:0]  H_RXDATA     = 8'h08;
	localparam logic [7:0]  H_STATUS     = 8'h0C;
	localparam int          CTRL_CNT_LSB = 8;
	localparam int          HOST_BYTES   = 4;
	// Link timing
	localparam int          CLK_NS       = 10;
	localparam int          SCK_HALF_NS  = 250;
	localparam int          SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;

	function automatic logic is_rw(input logic [5:0] a);
		return a inside {[6'h01:6'h07], 6'h0D, [6'h0F:6'h1A], 6'h1C, 6'h20, 6'h21,
			[6'h23:6'h24], 6'h26, [6'h2E:6'h2F], [6'h32:6'h33], 6'h38};
	endfunction : is_rw

	function automatic logic [7:0] reset_value(input logic [5:0] a);
		case (a) inside
			6'h05:                return 8'h01;
			6'h06:                return 8'h03;
			[A_CODE:A_CODE_LAST]: return 8'(CODE_RESET >> (8 * (a - A_CODE)));
			6'h19:                return 8'h08;
			6'h1A:                return 8'h38;
			6'h20:                return 8'h04;
			6'h38:                return 8'h64;
			default:              return 8'h00;
		endcase
	endfunction : reset_value

	function automatic logic [7:0] write_mask(input logic [5:0] a);
		return (a == A_SYNTH_A) ? SYNTH_A_MASK : (a == A_SYNTH_N) ? SYNTH_N_MASK : 8'hFF;
	endfunction : write_mask

	// Slot 0..7: rx status, rx byte 1, rx qual 1, rx byte 2, rx qual 2, tx status, wake status, strength
	function automatic logic [3:0] status_slot(input logic [5:0] a);
		case (a)
			6'h08:   return 4'h0;
			6'h09:   return 4'h1;
			6'h0A:   return 4'h2;
			6'h0B:   return 4'h3;
			6'h0C:   return 4'h4;
			6'h0E:   return 4'h5;
			6'h1D:   return 4'h6;
			6'h22:   return 4'h7;
			default: return 4'hF;
		endcase
	endfunction : status_slot

	function automatic logic [4:0] chan_to_a(input logic [6:0] ch);
		return ch[4:0];
	endfunction : chan_to_a

	function automatic logic [6:0] chan_to_n(input logic [6:0] ch);
		return SYNTH_N_BASE + {5'h00, ch[6:5]};
	endfunction : chan_to_n
endpackage : rad_pkg

// file: rad_spi_if.sv
`timescale 1ns/1ps
interface rad_spi_if;
	logic sck;
	logic mosi;
	logic ss_n;
	logic miso;
	logic miso_oe;
	logic miso_line;

	// Undriven line reads low
	assign miso_line = miso_oe & miso;

	modport dev  (input sck, input mosi, input ss_n, output miso, output miso_oe);
	modport host (output sck, output mosi, output ss_n, input miso_line);
endinterface : rad_spi_if

// file: rad_sync.sv
`timescale 1ns/1ps
module rad_sync #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= RESET_VAL;
			q    <= RESET_VAL;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : rad_sync

// file: rad_dev.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module rad_dev #(
	parameter logic [3:0]  SILICON_REV  = 4'h2,        // Arbitrary value
	parameter logic [3:0]  PRODUCT_CODE = 4'hA,        // Arbitrary value
	parameter logic [31:0] MFG_ID       = 32'hC3A50F96 // Arbitrary value
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	rad_spi_if.dev                    spi,
	input  wire logic [7:0][7:0]      status_bytes,
	output logic      [63:0][7:0]     regs,
	output logic                      counter_mode,
	output logic      [4:0]           synth_a,
	output logic      [6:0]           synth_n
);
	logic       s_sck;
	logic       s_mosi;
	logic       s_ss_n;
	logic       sck_d;
	logic [2:0] bit_cnt;
	logic [7:0] in_sh;
	logic [7:0] tx_sh;
	logic       have_cmd;
	logic       dir_wr;
	logic       inc;
	logic [5:0] addr;
	logic       miso;

	wire        sel;
	wire        sck_rise;
	wire        sck_fall;
	wire [7:0]  byte_in;
	wire        byte_done;
	wire [5:0]  next_addr;
	wire [5:0]  rd_addr;
	wire [3:0]  slot;
	wire        chan_mode_rd;
	wire [6:0]  chan_num;
	wire [4:0]  chan_a;
	wire [6:0]  chan_n;
	wire [7:0]  rd_data;
	wire        wr_en;
	wire        cmd_done;
	wire        data_done;
	wire        rd_rev;
	wire        rd_mfg;
	wire        rd_syn_a;
	wire        rd_syn_n;
	wire        rd_status;
	wire        rd_rw;

	rad_sync #(
		.WIDTH     (3),
		.RESET_VAL (3'b001)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({spi.sck, spi.mosi, spi.ss_n}),
		.q   ({s_sck, s_mosi, s_ss_n})
	);

	// Link edge detection on synchronised levels
	assign sel       = ~s_ss_n;
	assign sck_rise  = sel & s_sck & ~sck_d;
	assign sck_fall  = sel & ~s_sck & sck_d;
	assign byte_in   = {in_sh[6:0], s_mosi};
	assign byte_done = sck_rise & (bit_cnt == 3'h7);
	assign cmd_done  = byte_done & ~have_cmd;
	assign data_done = byte_done & have_cmd;
	assign next_addr = inc ? 6'(addr + 6'h01) : addr;

	// Address of the byte shifted out next
	assign rd_addr   = have_cmd ? next_addr : byte_in[5:0];

	// Channel value to divider counts
	assign chan_num     = regs[rad_pkg::A_CHANNEL][6:0];
	assign chan_a       = rad_pkg::chan_to_a(chan_num);
	assign chan_n       = rad_pkg::chan_to_n(chan_num);
	assign chan_mode_rd = ~regs[rad_pkg::A_CHANNEL][rad_pkg::CHAN_MODE];
	assign slot         = rad_pkg::status_slot(rd_addr);

	// Source of the byte shifted out next
	assign rd_rev    = (rd_addr == rad_pkg::A_REVISION);
	assign rd_mfg    = (rd_addr >= rad_pkg::A_MFG);
	assign rd_syn_a  = chan_mode_rd & (rd_addr == rad_pkg::A_SYNTH_A);
	assign rd_syn_n  = chan_mode_rd & (rd_addr == rad_pkg::A_SYNTH_N);
	assign rd_status = (slot != 4'hF);
	assign rd_rw     = rad_pkg::is_rw(rd_addr);

	// Read selection
	assign rd_data =
		rd_rev    ? {SILICON_REV, PRODUCT_CODE} :
		rd_mfg    ? MFG_ID[{rd_addr[1:0], 3'h0} +: 8] :
		rd_syn_a  ? {3'h0, chan_a} :
		rd_syn_n  ? {1'h0, chan_n} :
		rd_status ? status_bytes[slot[2:0]] :
		rd_rw     ? regs[rd_addr] :
		8'h00;

	// Only mapped writable addresses take data
	assign wr_en = byte_done & have_cmd & dir_wr & rad_pkg::is_rw(addr);

	assign spi.miso    = miso;
	assign spi.miso_oe = sel;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sck_d <= 1'b0;
		end else begin
			sck_d <= s_sck;
		end
	end

	// Bit position within the current byte
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_cnt <= 3'h0;
		end else if (!sel) begin
			bit_cnt <= 3'h0;
		end else if (sck_rise) begin
			bit_cnt <= 3'(bit_cnt + 3'h1);
		end
	end

	// Incoming bits, most significant first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			in_sh <= 8'h00;
		end else if (sck_rise) begin
			in_sh <= byte_in;
		end
	end

	// Command byte capture; deselect clears have_cmd only, dir_wr and inc keep their values
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			have_cmd <= 1'b0;
			dir_wr   <= 1'b0;
			inc      <= 1'b0;
		end else if (!sel) begin
			have_cmd <= 1'b0;
		end else if (cmd_done) begin
			have_cmd <= 1'b1;
			dir_wr   <= byte_in[rad_pkg::CMD_DIR_BIT];
			inc      <= byte_in[rad_pkg::CMD_INC_BIT];
		end
	end

	// Register address, stepped after each data byte when the command's increment bit is set
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			addr <= 6'h00;
		end else if (cmd_done) begin
			addr <= byte_in[5:0];
		end else if (data_done) begin
			addr <= next_addr;
		end
	end

	// Read data out, changed on falling link clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_sh <= 8'h00;
			miso  <= 1'b0;
		end else if (byte_done) begin
			tx_sh <= rd_data;
		end else if (sck_fall) begin
			miso  <= tx_sh[7];
			tx_sh <= {tx_sh[6:0], 1'b0};
		end
	end

	// Register storage, reserved count bits held at zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 64; i++) begin
				regs[i] <= rad_pkg::reset_value(6'(i));
			end
		end else if (wr_en) begin
			regs[addr] <= byte_in & rad_pkg::write_mask(addr);
		end
	end

	// Synthesizer divider source
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			counter_mode <= 1'b0;
			synth_a      <= 5'h00;
			synth_n      <= 7'h00;
		end else begin
			counter_mode <= ~chan_mode_rd;
			synth_a      <= chan_mode_rd ? chan_a : regs[rad_pkg::A_SYNTH_A][4:0];
			synth_n      <= chan_mode_rd ? chan_n : regs[rad_pkg::A_SYNTH_N][6:0];
		end
	end
endmodule : rad_dev

// file: rad_host.sv
`timescale 1ns/1ps
module rad_host #(
	parameter int SCK_HALF = rad_pkg::SCK_HALF_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	rad_spi_if.host          spi
);
	typedef enum logic {RAD_IDLE, RAD_RUN} rad_state_type;

	rad_state_type state;
	logic [15:0]   div_cnt;
	logic          sck;
	logic          ss_n;
	logic          mosi;
	logic [6:0]    sh;
	logic [7:0]    rsh;
	logic [2:0]    bit_cnt;
	logic [2:0]    byte_idx;
	logic [1:0]    last;
	logic [31:0]   tx_word;
	logic [31:0]   rx_word;
	logic          miso_s;

	wire           busy;
	wire           start;
	wire           tick;
	wire [7:0]     rx_byte;
	wire [2:0]     prev_idx;
	wire [7:0]     next_byte;

	rad_sync #(
		.WIDTH     (1),
		.RESET_VAL (1'b0)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.d   (spi.miso_line),
		.q   (miso_s)
	);

	assign busy      = (state == RAD_RUN);
	assign start     = wr & ~busy & (addr == rad_pkg::H_CTRL);
	assign tick      = busy & (div_cnt == 16'(SCK_HALF - 1));
	assign rx_byte   = {rsh[6:0], miso_s};
	assign prev_idx  = 3'(byte_idx - 3'h1);
	// Data bytes leave lowest first
	assign next_byte = tx_word[{byte_idx[1:0], 3'h0} +: 8];

	assign spi.sck  = sck;
	assign spi.ss_n = ss_n;
	assign spi.mosi = mosi;

	// Link sequencing, slave select held over the whole burst
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state    <= RAD_IDLE;
			div_cnt  <= 16'h0000;
			sck      <= 1'b0;
			ss_n     <= 1'b1;
			mosi     <= 1'b0;
			sh       <= 7'h00;
			rsh      <= 8'h00;
			bit_cnt  <= 3'h0;
			byte_idx <= 3'h0;
			last     <= 2'h0;
			rx_word  <= 32'h00000000;
		end else if (start) begin
			state    <= RAD_RUN;
			div_cnt  <= 16'h0000;
			ss_n     <= 1'b0;
			mosi     <= wdata[7];
			sh       <= wdata[6:0];
			bit_cnt  <= 3'h0;
			byte_idx <= 3'h0;
			last     <= wdata[rad_pkg::CTRL_CNT_LSB +: 2];
		end else if (busy) begin
			div_cnt <= tick ? 16'h0000 : 16'(div_cnt + 16'h0001);
			if (tick && !sck) begin
				sck <= 1'b1;
				rsh <= rx_byte;
				if (bit_cnt == 3'h7 && byte_idx != 3'h0) begin
					rx_word[{prev_idx[1:0], 3'h0} +: 8] <= rx_byte;
				end
			end else if (tick) begin
				sck     <= 1'b0;
				bit_cnt <= 3'(bit_cnt + 3'h1);
				if (bit_cnt == 3'h7 && byte_idx == {1'b0, last} + 3'h1) begin
					state <= RAD_IDLE;
					ss_n  <= 1'b1;
					mosi  <= 1'b0;
				end else if (bit_cnt == 3'h7) begin
					byte_idx <= 3'(byte_idx + 3'h1);
					mosi     <= next_byte[7];
					sh       <= next_byte[6:0];
				end else begin
					mosi <= sh[6];
					sh   <= {sh[5:0], 1'b0};
				end
			end
		end
	end

	// Controller registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_word <= 32'h00000000;
			rdata   <= 32'h00000000;
		end else begin
			if (wr && !busy && addr == rad_pkg::H_TXDATA) begin
				tx_word <= wdata;
			end
			if (rd) begin
				case (addr)
					rad_pkg::H_TXDATA: rdata <= tx_word;
					rad_pkg::H_RXDATA: rdata <= rx_word;
					rad_pkg::H_STATUS: rdata <= {31'h00000000, busy};
					default:           rdata <= 32'h00000000;
				endcase
			end else begin
				rdata <= 32'h00000000;
			end
		end
	end
endmodule : rad_host

// file: rad_chk.sv
`timescale 1ns/1ps
module rad_chk #(
	parameter int HALF = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic mosi,
	input wire logic ss_n,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic miso_line
);
	logic [7:0] hi_cnt;
	logic [7:0] lo_cnt;
	logic [7:0] bits;
	logic       sck_q;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// Phase lengths and bits per frame
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hi_cnt <= 8'h00;
			lo_cnt <= 8'h00;
			bits   <= 8'h00;
			sck_q  <= 1'b0;
		end else begin
			hi_cnt <= sck ? hi_cnt + 8'h01 : 8'h00;
			lo_cnt <= (!sck && !ss_n) ? lo_cnt + 8'h01 : 8'h00;
			bits   <= ss_n ? 8'h00 : bits + {7'h00, sck & !sck_q};
			sck_q  <= sck;
		end
	end
	sck_idle_a: assert property (ss_n |-> !sck)
		else $error("sck active while deselected");
	high_phase_a: assert property ($fell(sck) |-> hi_cnt == 8'(HALF))
		else $error("sck high phase wrong");
	low_phase_a: assert property ($rose(sck) |-> lo_cnt >= 8'(HALF))
		else $error("sck low phase short");
	mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi))
		else $error("mosi moved while sck high");
	frame_bytes_a: assert property ($rose(ss_n) |-> bits[2:0] == 3'h0 && bits >= 8'h10)
		else $error("frame not whole bytes");
	start_wait_a: assert property ($fell(ss_n) |-> !sck [*4])
		else $error("sck too soon after select");
	frame_gap_a: assert property ($rose(ss_n) |-> ss_n [*2])
		else $error("deselect gap short");
	drive_on_a: assert property ($fell(ss_n) |-> ##[1:4] miso_oe)
		else $error("miso not driven when selected");
	drive_off_a: assert property (ss_n [*4] |-> !miso_oe)
		else $error("miso driven while deselected");
	miso_hold_a: assert property (miso_oe && sck && $past(sck) |-> $stable(miso))
		else $error("miso moved while sck high");
	cover property ($rose(ss_n) && bits == 8'h10);
	cover property ($rose(ss_n) && bits == 8'h28);
	cover property (miso_oe && miso_line);
endmodule : rad_chk

// file: tb_radio_register_map.sv
`timescale 1ns/1ps
module tb_radio_register_map;
	localparam logic [3:0]  SREV  = 4'h3;         // Arbitrary value
	localparam logic [3:0]  PCODE = 4'h5;         // Arbitrary value
	localparam logic [31:0] MFG   = 32'h5A17C0DE; // Arbitrary value
	localparam int          HALF  = 6;
	logic             clk = 1'b0;
	logic             rst = 1'b1;
	logic [7:0]       addr = 8'h00;
	logic [31:0]      wdata = 32'h0;
	logic             wr = 1'b0;
	logic             rd = 1'b0;
	logic [31:0]      rdata;
	logic [7:0][7:0]  status_bytes = 64'h0;
	logic [63:0][7:0] regs;
	logic             counter_mode;
	logic [4:0]       synth_a;
	logic [6:0]       synth_n;
	logic [31:0]      got;
	int               num_errors = 0;
	int               checks_done = 0;
	int               seed = 67;
	int               mem [64];
	rad_spi_if spi ();
	rad_dev #(.SILICON_REV(SREV), .PRODUCT_CODE(PCODE), .MFG_ID(MFG)) u_rad_dev (.clk(clk), .rst(rst),
		.spi(spi), .status_bytes(status_bytes), .regs(regs), .counter_mode(counter_mode),
		.synth_a(synth_a), .synth_n(synth_n));
	rad_host #(.SCK_HALF(HALF)) u_rad_host (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .spi(spi));
	rad_chk #(.HALF(HALF)) u_rad_chk (.clk(clk), .rst(rst), .sck(spi.sck), .mosi(spi.mosi),
		.ss_n(spi.ss_n), .miso(spi.miso), .miso_oe(spi.miso_oe), .miso_line(spi.miso_line));
	always #5 clk = ~clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic int rw(int a);
		return a inside {[1:7], 13, [15:26], 28, 32, 33, 35, 36, 38, 46, 47, 50, 51, 56};
	endfunction : rw
	task automatic mreset();
		foreach (mem[i])
			mem[i] = 0;
		mem[5] = 1;
		mem[6] = 3;
		mem[25] = 8;
		mem[26] = 56;
		mem[32] = 4;
		mem[56] = 100;
		for (int i = 0; i < 8; i++)
			mem[17 + i] = 8'(64'h1E8B6A3DE0E9B222 >> (8 * i));
	endtask : mreset
	function automatic int mrd(int a);
		int ch = mem[33];
		case (a)
			0:                return {SREV, PCODE};
			1:                return ch[7] ? mem[1] : ch % 32;
			2:                return ch[7] ? mem[2] : 74 + ch[6:5];
			8, 9, 10, 11, 12: return status_bytes[a - 8];
			14:               return status_bytes[5];
			29:               return status_bytes[6];
			34:               return status_bytes[7];
			60, 61, 62, 63:   return 8'(MFG >> (8 * (a - 60)));
			default:          return rw(a) ? mem[a] : 0;
		endcase
	endfunction : mrd
	task automatic mwr(int a, int d);
		if (rw(a))
			mem[a] = d & (a == 1 ? 31 : a == 2 ? 127 : 255);
	endtask : mwr
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s exp %0h seen %0h", nm, exp, seen);
		end
	endtask : check
	task end_of_test();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	task automatic wreg(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 got = rdata;
	endtask : rreg
	task automatic xfer(logic [7:0] cmd, int n, logic [31:0] d);
		int i;
		wreg(rad_pkg::H_TXDATA, d);
		rreg(rad_pkg::H_TXDATA);
		check("txdata", got, d);
		wreg(rad_pkg::H_CTRL, {22'h0, 2'(n - 1), cmd});
		got = 32'h1;
		for (i = 0; i < 1000 && got[0] !== 1'b0; i++)
			rreg(rad_pkg::H_STATUS);
		if (got[0] !== 1'b0) begin
			num_errors++;
			end_of_test();
		end
		rreg(rad_pkg::H_RXDATA);
	endtask : xfer
	task automatic rdn(int a, logic inc, int n);
		int ad;
		xfer({1'b0, inc, 6'(a)}, n, 32'h0);
		for (int k = 0; k < n; k++) begin
			ad = inc ? (a + k) % 64 : a;
			check($sformatf("rd %0h", ad), 32'(got[8 * k +: 8]), mrd(ad));
		end
	endtask : rdn
	task automatic wrn(int a, logic inc, int n, logic [31:0] d);
		xfer({1'b1, inc, 6'(a)}, n, d);
		for (int k = 0; k < n; k++)
			mwr(inc ? (a + k) % 64 : a, d[8 * k +: 8]);
	endtask : wrn
	task automatic chk_out(string t);
		for (int i = 0; i < 64; i++)
			check("regs", 32'(regs[i]), mem[i]);
		check("mode", 32'(counter_mode), mem[33] / 128);
		check("syn_a", 32'(synth_a), mrd(1));
		check("syn_n", 32'(synth_n), mrd(2));
		$display("test %s done", t);
	endtask : chk_out
	task automatic readall(string t);
		for (int a = 0; a < 64; a += 4)
			rdn(a, 1'b1, 4);
		chk_out(t);
	endtask : readall
	initial begin
		logic [31:0] d;
		mreset();
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		status_bytes <= {rnd(), rnd()};
		readall("defaults");
		for (int a = 0; a < 64; a += 4) begin
			d = rnd();
			if (a == 0)
				d[23:8] = {8'(74 + d[23:16] % 3), 3'h0, d[12:8]};
			wrn(a, 1'b1, 4, d);
		end
		@(posedge clk);
		status_bytes <= {rnd(), rnd()};
		readall("random");
		for (int a = 0; a < 3; a++) begin
			wrn(1, 1'b1, 2, {16'h0, 8'(74 + a), 3'h0, 5'(rnd())});
			wrn(33, 1'b0, 1, 32'(128 + a));
			rdn(1, 1'b1, 2);
			chk_out("counter");
			wrn(33, 1'b0, 1, 32'(a * 32 + 9));
			rdn(1, 1'b1, 2);
			chk_out("channel");
		end
		wrn(35, 1'b0, 4, rnd());
		rdn(35, 1'b0, 4);
		rdn(62, 1'b1, 4);
		chk_out("burst");
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		mreset();
		readall("rereset");
		end_of_test();
	end
endmodule : tb_radio_register_map
